// *** hdl/acd_pkg.sv ***
// Constants and types shared by the audio clock detect and configuration block
package acd_pkg;
   // --------------------------------------------------------------
   // Control-port register map
   // --------------------------------------------------------------
   localparam logic [6:0] OFS_PAGE_WRAP      = 7'h0f;
   localparam logic [6:0] OFS_RATIO_MODE     = 7'h28;
   localparam logic [6:0] OFS_CHECK_IGNORE   = 7'h29;
   localparam logic [6:0] OFS_SOURCE_SELECT  = 7'h30;
   localparam logic [6:0] PAGE_SELECT_ADDR   = 7'h00;
   localparam logic [6:0] BOOK_SELECT_ADDR   = 7'h7f;
   localparam logic [6:0] PAGE_LAST_ADDR     = 7'h7f;
   localparam logic [6:0] NEXT_PAGE_START    = 7'h08;
   localparam logic [6:0] SAME_PAGE_START    = 7'h00;
   localparam logic [7:0] RST_PAGE_WRAP      = 8'h00;
   localparam logic [7:0] RST_RATIO_MODE     = 8'h00;
   localparam logic [7:0] RST_CHECK_IGNORE   = 8'h00;
   localparam logic [7:0] RST_SOURCE_SELECT  = 8'h00;
   // Field positions
   localparam int BIT_PAGE_WRAP_DISABLE = 3;
   localparam int BIT_IGN_PLL           = 6;
   localparam int BIT_IGN_RANGE         = 5;
   localparam int BIT_IGN_FS            = 4;
   localparam int BIT_IGN_RATIO         = 3;
   localparam int BIT_IGN_MISSING       = 2;
   localparam int BIT_SOURCE_SELECT     = 0;
   localparam int RATIO_MSB = 7;
   localparam int RATIO_LSB = 4;
   localparam int MODE_MSB  = 3;
   localparam int MODE_LSB  = 0;
   // --------------------------------------------------------------
   // Encodings
   // --------------------------------------------------------------
   localparam logic [3:0] RATIO_32   = 4'h3;
   localparam logic [3:0] RATIO_64   = 4'h5;
   localparam logic [3:0] RATIO_128  = 4'h7;
   localparam logic [3:0] RATIO_256  = 4'h9;
   localparam logic [3:0] RATIO_512  = 4'hb;
   localparam logic [3:0] RATE_AUTO  = 4'h0;
   localparam logic [3:0] RATE_ERROR = 4'h0;
   localparam logic [3:0] RATE_32K   = 4'h6;
   localparam logic [3:0] RATE_44K1  = 4'h8;
   localparam logic [3:0] RATE_48K   = 4'h9;
   localparam logic [3:0] RATE_88K2  = 4'ha;
   localparam logic [3:0] RATE_96K   = 4'hb;
   localparam logic [9:0] RATIO_MIN_BCK = 10'h020;
   localparam logic [9:0] RATIO_MAX_BCK = 10'h200;
   // --------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------
   localparam int CLK_HZ          = 10_000_000;
   localparam int BCK_MIN_HZ      = 256_000;
   localparam int BCK_MAX_HZ      = 50_000_000;
   localparam int BCK_MISSING_NS  = 20_000;
   localparam int CLK_NS          = 1_000_000_000 / CLK_HZ;
   // Longest allowed bit clock period, rounded down
   localparam int BCK_MAX_PER_CYC = CLK_HZ / BCK_MIN_HZ;
   // Shortest allowed period, rounded up, never under one cycle
   localparam int BCK_MIN_PER_RAW = (CLK_HZ + BCK_MAX_HZ - 1) / BCK_MAX_HZ;
   localparam int BCK_MIN_PER_CYC = (BCK_MIN_PER_RAW < 1) ? 1 : BCK_MIN_PER_RAW;
   localparam int BCK_MISSING_CYC = BCK_MISSING_NS / CLK_NS;
   localparam int FRAME_MISSING_CYC = 1023;
   // Nominal frame periods in clock cycles and the window around them
   localparam int FS_TOL_CYC   = 3;
   localparam int PER_32K_CYC  = CLK_HZ / 32_000;
   localparam int PER_44K1_CYC = CLK_HZ / 44_100;
   localparam int PER_48K_CYC  = CLK_HZ / 48_000;
   localparam int PER_88K2_CYC = CLK_HZ / 88_200;
   localparam int PER_96K_CYC  = CLK_HZ / 96_000;
   // --------------------------------------------------------------
   // Types
   // --------------------------------------------------------------
   typedef struct packed {
      logic pll_overrate;
      logic bck_range;
      logic sample_rate;
      logic bck_ratio;
      logic bck_missing;
   } acd_faults_t;
endpackage

// *** hdl/acd_period_meter.sv ***
// Measures the clock-cycle spacing of edge pulses and flags a timeout
`timescale 1ns/100ps
module acd_period_meter #(
   parameter int W       = 10,
   parameter int TIMEOUT = 200
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         edge_pulse,
   output logic [W-1:0]      period_reg,
   output logic              valid_reg,
   output logic              timeout_reg
);
   localparam logic [W-1:0] CNT_MAX = {W{1'b1}};
   localparam logic [W-1:0] TO_CNT  = W'(TIMEOUT);

   // Elaboration-time refusal of a timeout that the saturating counter cannot reach
   if (TIMEOUT < 1 || TIMEOUT >= (1 << W)) begin : g_bad_timeout
      $error("acd_period_meter: TIMEOUT does not fit the counter");
   end

   logic [W-1:0] count_reg;

   // Counter saturates so a stopped clock never wraps into a fake period
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         count_reg <= '0;
      else if (edge_pulse)
         count_reg <= W'(1);
      else if (count_reg != CNT_MAX)
         count_reg <= count_reg + W'(1);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         period_reg <= '0;
         valid_reg  <= 1'b0;
      end else if (edge_pulse) begin
         period_reg <= count_reg;
         valid_reg  <= (count_reg != '0);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         timeout_reg <= 1'b1;
      else if (edge_pulse)
         timeout_reg <= 1'b0;
      else if (count_reg >= TO_CNT)
         timeout_reg <= 1'b1;
   end
endmodule

// *** hdl/acd_clock_detect_config.sv ***
// Control-port configuration registers and audio clock fault detection
`timescale 1ns/100ps
// Operation
// RL1: With page wrap disable at 0, a non-zero-book access past page end goes to address 8 of the next page.
// RL2: With page wrap disable at 1, an access past page end goes to address 0 of the same page.
// RL3: The ratio field holds bit clocks per frame: 3=32, 5=64, 7=128, 9=256, 11=512 times fs.
// RL4: The rate mode field is 0 for auto or 6/8/9/10/11 for 32/44.1/48/88.2/96 kHz and must match.
// RL5: A PLL overrate fault is reported and raises clock error unless its ignore bit 6 is set.
// RL6: A bit clock outside 256 kHz to 50 MHz is a range fault, raising clock error unless bit 5 is set; the code flags only periods over 39 cycles.
// RL7: With bit 4 set a sample rate fault raises no clock error but still shows in status.
// RL8: Bit clocks per frame outside 32 to 512 is a ratio fault, kept from clock error by bit 3.
// RL9: A missing bit clock raises clock error unless bit 2 is set.
// RL10: Source select bit 0 picks processed output (0) or unprocessed input (1) for serial out.
// RL11: The detected rate is reported as a 4-bit code, 0 meaning a rate error.
// RL12: Clock error is the OR of all faults whose ignore bit is clear; every fault stays visible.
// RL13: Software writes zero to reserved bits and no reserved ratio or mode codes.
module acd_clock_detect_config (
   input  wire logic                 CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 CP_START,
   input  wire logic [6:0]           CP_ADDR,
   input  wire logic                 CP_WR,
   input  wire logic [7:0]           CP_WDATA,
   input  wire logic                 CP_RD,
   output logic [7:0]                CP_RDATA,
   output logic                      CP_RVALID,
   output logic [6:0]                CP_POINTER,
   output logic [7:0]                CP_PAGE,
   output logic [7:0]                CP_BOOK,
   input  wire logic                 SERIAL_BIT_CLOCK,
   input  wire logic                 FRAME_CLOCK,
   input  wire logic                 SERIAL_DATA_IN,
   input  wire logic                 DSP_POST_DATA,
   input  wire logic                 PLL_OVERRATE,
   output logic                      SERIAL_AUDIO_OUTPUT,
   output acd_pkg::acd_faults_t      CLOCK_DETECT_STATUS,
   output logic                      CLOCK_ERROR,
   output logic [3:0]                DETECTED_RATE_MONITOR,
   output logic [3:0]                CONFIGURED_BIT_CLOCK_RATIO,
   output logic [3:0]                SAMPLE_RATE_MODE
);
   import acd_pkg::*;

   // --------------------------------------------------------------
   // Configuration registers and control-port pointer
   // --------------------------------------------------------------
   logic [7:0] page_wrap_reg, ratio_mode_reg, check_ignore_reg, source_select_reg;
   logic [6:0] pointer_reg;
   logic [7:0] page_reg, book_reg;
   logic       access;
   logic       at_page_end;
   logic       page_wrap_disable;
   logic       sel_page0;

   assign access            = CP_WR | CP_RD;
   assign at_page_end       = (pointer_reg == PAGE_LAST_ADDR);
   assign page_wrap_disable = page_wrap_reg[BIT_PAGE_WRAP_DISABLE];
   assign sel_page0         = (book_reg == 8'h00) && (page_reg == 8'h00);

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         pointer_reg <= '0;
      else if (CP_START)
         pointer_reg <= CP_ADDR;
      else if (access && at_page_end) begin
         if (book_reg != 8'h00 && !page_wrap_disable)
            pointer_reg <= NEXT_PAGE_START;   // [RL1]
         else
            pointer_reg <= SAME_PAGE_START;   // [RL2]
      end else if (access)
         pointer_reg <= pointer_reg + 7'h01;
   end

   // Page select lives at address 0 of every page; a write there wins over a page advance
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         page_reg <= '0;
      else if (CP_WR && !CP_START && pointer_reg == PAGE_SELECT_ADDR)
         page_reg <= CP_WDATA;
      else if (access && !CP_START && at_page_end && book_reg != 8'h00
               && !page_wrap_disable)
         page_reg <= page_reg + 8'h01;   // [RL1]
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         book_reg <= '0;
      else if (CP_WR && !CP_START && page_reg == 8'h00 && pointer_reg == BOOK_SELECT_ADDR)
         book_reg <= CP_WDATA;
   end

   // Reserved bits are stored as written; software is expected to keep them zero
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         page_wrap_reg     <= RST_PAGE_WRAP;
         ratio_mode_reg    <= RST_RATIO_MODE;
         check_ignore_reg  <= RST_CHECK_IGNORE;
         source_select_reg <= RST_SOURCE_SELECT;
      end else if (CP_WR && !CP_START && sel_page0) begin
         unique case (pointer_reg)
            OFS_PAGE_WRAP:     page_wrap_reg     <= CP_WDATA;
            OFS_RATIO_MODE:    ratio_mode_reg    <= CP_WDATA;   // [RL3] [RL4]
            OFS_CHECK_IGNORE:  check_ignore_reg  <= CP_WDATA;
            OFS_SOURCE_SELECT: source_select_reg <= CP_WDATA;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CP_RDATA  <= '0;
         CP_RVALID <= 1'b0;
      end else begin
         CP_RVALID <= CP_RD && !CP_START;
         if (CP_RD && !CP_START) begin
            CP_RDATA <= 8'h00;
            if (sel_page0) begin
               unique case (pointer_reg)
                  OFS_PAGE_WRAP:     CP_RDATA <= page_wrap_reg;
                  OFS_RATIO_MODE:    CP_RDATA <= ratio_mode_reg;
                  OFS_CHECK_IGNORE:  CP_RDATA <= check_ignore_reg;
                  OFS_SOURCE_SELECT: CP_RDATA <= source_select_reg;
                  default:           CP_RDATA <= 8'h00;
               endcase
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CP_POINTER                 <= '0;
         CP_PAGE                    <= '0;
         CP_BOOK                    <= '0;
         CONFIGURED_BIT_CLOCK_RATIO <= '0;
         SAMPLE_RATE_MODE           <= '0;
      end else begin
         CP_POINTER                 <= pointer_reg;
         CP_PAGE                    <= page_reg;
         CP_BOOK                    <= book_reg;
         CONFIGURED_BIT_CLOCK_RATIO <= ratio_mode_reg[RATIO_MSB:RATIO_LSB];   // [RL3]
         SAMPLE_RATE_MODE           <= ratio_mode_reg[MODE_MSB:MODE_LSB];     // [RL4]
      end
   end

   // --------------------------------------------------------------
   // Pin synchronisers and edge detection
   // --------------------------------------------------------------
   logic [2:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic       bck_rise, frame_rise;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end else begin
         pin_meta_reg <= {SERIAL_DATA_IN, FRAME_CLOCK, SERIAL_BIT_CLOCK};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   assign bck_rise   = pin_sync_reg[0] & ~pin_prev_reg[0];
   assign frame_rise = pin_sync_reg[1] & ~pin_prev_reg[1];

   // --------------------------------------------------------------
   // Clock measurement
   // --------------------------------------------------------------
   logic [9:0] bck_period, frame_period;
   logic       bck_valid, frame_valid, bck_missing, frame_missing;

   acd_period_meter #(.W(10), .TIMEOUT(BCK_MISSING_CYC)) u_bck_meter (
      .clk         (CLK),
      .reset_n     (RESET_N),
      .edge_pulse  (bck_rise),
      .period_reg  (bck_period),
      .valid_reg   (bck_valid),
      .timeout_reg (bck_missing)
   );

   acd_period_meter #(.W(10), .TIMEOUT(FRAME_MISSING_CYC)) u_frame_meter (
      .clk         (CLK),
      .reset_n     (RESET_N),
      .edge_pulse  (frame_rise),
      .period_reg  (frame_period),
      .valid_reg   (frame_valid),
      .timeout_reg (frame_missing)
   );

   // Bit clocks per frame; saturates so a runaway count still reads as too many
   logic [9:0] bck_count_reg, ratio_reg;
   logic       ratio_valid_reg;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bck_count_reg   <= '0;
         ratio_reg       <= '0;
         ratio_valid_reg <= 1'b0;
      end else if (frame_rise) begin
         bck_count_reg   <= {9'h000, bck_rise};
         ratio_reg       <= bck_count_reg;
         ratio_valid_reg <= 1'b1;
      end else if (bck_rise && bck_count_reg != 10'h3ff)
         bck_count_reg <= bck_count_reg + 10'h001;
   end

   function automatic logic in_window(input logic [9:0] per, input int nominal);
      in_window = (int'(per) >= nominal - FS_TOL_CYC) && (int'(per) <= nominal + FS_TOL_CYC);
   endfunction

   logic [3:0]  rate_code;
   acd_faults_t faults;

   always_comb begin
      rate_code = RATE_ERROR;
      if (frame_valid && !frame_missing) begin
         if (in_window(frame_period, PER_32K_CYC))
            rate_code = RATE_32K;
         else if (in_window(frame_period, PER_44K1_CYC))
            rate_code = RATE_44K1;
         else if (in_window(frame_period, PER_48K_CYC))
            rate_code = RATE_48K;
         else if (in_window(frame_period, PER_88K2_CYC))
            rate_code = RATE_88K2;
         else if (in_window(frame_period, PER_96K_CYC))
            rate_code = RATE_96K;
      end
   end

   // A bit clock faster than one cycle cannot be seen at this sample rate
   always_comb begin
      faults.pll_overrate = PLL_OVERRATE;                                   // [RL5]
      faults.bck_missing  = bck_missing;                                    // [RL9]
      faults.bck_range    = !bck_missing && bck_valid &&
                            (int'(bck_period) > BCK_MAX_PER_CYC ||
                             int'(bck_period) < BCK_MIN_PER_CYC);           // [RL6]
      faults.bck_ratio    = ratio_valid_reg &&
                            (ratio_reg < RATIO_MIN_BCK || ratio_reg > RATIO_MAX_BCK); // [RL8]
      faults.sample_rate  = (rate_code == RATE_ERROR) ||
                            (SAMPLE_RATE_MODE != RATE_AUTO &&
                             SAMPLE_RATE_MODE != rate_code);                // [RL4]
   end

   // --------------------------------------------------------------
   // Status, clock error and serial output
   // --------------------------------------------------------------
   acd_faults_t ignore_mask;
   assign ignore_mask = {check_ignore_reg[BIT_IGN_PLL], check_ignore_reg[BIT_IGN_RANGE],
                         check_ignore_reg[BIT_IGN_FS], check_ignore_reg[BIT_IGN_RATIO],
                         check_ignore_reg[BIT_IGN_MISSING]};

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CLOCK_DETECT_STATUS   <= '0;
         CLOCK_ERROR           <= 1'b0;
         DETECTED_RATE_MONITOR <= RATE_ERROR;
      end else begin
         CLOCK_DETECT_STATUS   <= faults;                        // [RL7] [RL12]
         CLOCK_ERROR           <= |(faults & ~ignore_mask);      // [RL5] [RL6] [RL8] [RL9] [RL12]
         DETECTED_RATE_MONITOR <= rate_code;                     // [RL11]
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         SERIAL_AUDIO_OUTPUT <= 1'b0;
      else
         SERIAL_AUDIO_OUTPUT <= source_select_reg[BIT_SOURCE_SELECT] ?
                                pin_sync_reg[2] : DSP_POST_DATA;   // [RL10]
   end

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   a_wrap_next_page: assert property (   // [RL1]
      (access && !CP_START && at_page_end && book_reg != 8'h00 && !page_wrap_disable)
      |=> (pointer_reg == NEXT_PAGE_START && page_reg == $past(page_reg) + 8'h01))
      else $error("page end did not advance to next page");
   a_wrap_same_page: assert property (   // [RL2]
      (access && !CP_START && at_page_end && page_wrap_disable)
      |=> (pointer_reg == SAME_PAGE_START && page_reg == $past(page_reg)))
      else $error("page end did not wrap within page");
   a_ratio_field: assert property (   // [RL3]
      (CP_WR && !CP_START && sel_page0 && pointer_reg == OFS_RATIO_MODE)
      |-> ##2 CONFIGURED_BIT_CLOCK_RATIO == $past(CP_WDATA[7:4], 2))
      else $error("ratio field not stored");
   a_pll_error: assert property (   // [RL5]
      (PLL_OVERRATE && !check_ignore_reg[BIT_IGN_PLL]) |=> CLOCK_ERROR)
      else $error("pll overrate did not raise clock error");
   a_range_error: assert property (   // [RL6]
      (faults.bck_range && !check_ignore_reg[BIT_IGN_RANGE]) |=> CLOCK_ERROR)
      else $error("bit clock range fault did not raise clock error");
   a_fs_ignored: assert property (   // [RL7]
      (faults == 5'b00100 && check_ignore_reg[BIT_IGN_FS])
      |=> (!CLOCK_ERROR && CLOCK_DETECT_STATUS.sample_rate))
      else $error("ignored rate fault misreported");
   a_ratio_error: assert property (   // [RL8]
      (faults.bck_ratio && !check_ignore_reg[BIT_IGN_RATIO]) |=> CLOCK_ERROR)
      else $error("ratio fault did not raise clock error");
   a_missing_error: assert property (   // [RL9]
      $rose(bck_missing) && !check_ignore_reg[BIT_IGN_MISSING] |=> CLOCK_ERROR)
      else $error("missing bit clock did not raise clock error");
   a_source_select: assert property (   // [RL10]
      !source_select_reg[BIT_SOURCE_SELECT] ##1 !source_select_reg[BIT_SOURCE_SELECT]
      |-> SERIAL_AUDIO_OUTPUT == $past(DSP_POST_DATA))
      else $error("serial output not taken from processed data");
   a_rate_monitor: assert property (   // [RL11]
      frame_missing |=> DETECTED_RATE_MONITOR == RATE_ERROR)
      else $error("rate monitor shows a rate without frames");
   a_no_false_error: assert property (   // [RL12]
      (faults & ~ignore_mask) == '0 |=> !CLOCK_ERROR)
      else $error("clock error without unmasked fault");

   c_next_page: cover property (access && at_page_end && book_reg != 8'h00 && !page_wrap_disable);
   c_rate_48k:  cover property (DETECTED_RATE_MONITOR == RATE_48K);
   c_bck_lost:  cover property ($rose(CLOCK_DETECT_STATUS.bck_missing));
   c_err_clear: cover property ($fell(CLOCK_ERROR));
endmodule

// *** bench/acd_audio_host_model.sv ***
// Behavioural audio host driving bit clock, frame clock and serial data
`timescale 1ns/100ps
module acd_audio_host_model (
   input  wire logic run,
   input  int        bits_per_frame,
   input  wire logic data_val,
   output logic      bit_clock,
   output logic      frame_clock,
   output logic      serial_data
);
   // -----------------------------------------------------------
   // Frames of bits_per_frame bit clocks at 800 ns
   // -----------------------------------------------------------
   always begin
      if (!run) begin
         // Idle: clocks stand still, data line shows the inverse
         bit_clock = 1'b0;
         frame_clock = 1'b0;
         serial_data = ~data_val;
         @(posedge run);
      end else begin
         for (int i = 0; i < bits_per_frame; i++) begin
            frame_clock = (i < bits_per_frame / 2);
            serial_data = data_val;
            #400 bit_clock = 1'b1;
            #400 bit_clock = 1'b0;
         end
      end
   end
endmodule

// *** bench/acd_clock_detect_config_tb.sv ***
// Self-checking bench for the audio clock detect and configuration block
`timescale 1ns/100ps
module acd_clock_detect_config_tb;
   import acd_pkg::*;
   logic CLK = 1'b0, RESET_N = 1'b0, CP_START = 1'b0, CP_WR = 1'b0, CP_RD = 1'b0;
   logic [6:0] CP_ADDR = 7'h00, CP_POINTER;
   logic [7:0] CP_WDATA = 8'h00, CP_RDATA, CP_PAGE, CP_BOOK;
   logic CP_RVALID, SERIAL_BIT_CLOCK, FRAME_CLOCK, SERIAL_DATA_IN, SERIAL_AUDIO_OUTPUT;
   logic DSP_POST_DATA = 1'b0, PLL_OVERRATE = 1'b0, CLOCK_ERROR, run = 1'b0, data_val = 1'b0;
   logic [3:0] DETECTED_RATE_MONITOR, CONFIGURED_BIT_CLOCK_RATIO, SAMPLE_RATE_MODE;
   acd_faults_t CLOCK_DETECT_STATUS;
   int bits = 39;
   int n_errors = 0;
   int num_checks = 0;
   always #50 CLK = ~CLK;
   acd_clock_detect_config i_dut (.CLK, .RESET_N, .CP_START, .CP_ADDR, .CP_WR, .CP_WDATA,
      .CP_RD, .CP_RDATA, .CP_RVALID, .CP_POINTER, .CP_PAGE, .CP_BOOK, .SERIAL_BIT_CLOCK,
      .FRAME_CLOCK, .SERIAL_DATA_IN, .DSP_POST_DATA, .PLL_OVERRATE, .SERIAL_AUDIO_OUTPUT,
      .CLOCK_DETECT_STATUS, .CLOCK_ERROR, .DETECTED_RATE_MONITOR,
      .CONFIGURED_BIT_CLOCK_RATIO, .SAMPLE_RATE_MODE);
   acd_audio_host_model i_host (.run(run), .bits_per_frame(bits), .data_val(data_val),
      .bit_clock(SERIAL_BIT_CLOCK), .frame_clock(FRAME_CLOCK), .serial_data(SERIAL_DATA_IN));
   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task settle(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task acc(input logic s, input logic w, input logic r, input logic [7:0] v);
      @(negedge CLK);
      CP_START = s;
      CP_WR = w;
      CP_RD = r;
      CP_ADDR = v[6:0];
      CP_WDATA = v;
      @(negedge CLK);
      CP_START = 1'b0;
      CP_WR = 1'b0;
      CP_RD = 1'b0;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, 1'b0, {1'b0, a});
      acc(1'b0, 1'b1, 1'b0, d);
   endtask
   task rd(input logic [6:0] a, input logic [7:0] e, input string n);
      acc(1'b1, 1'b0, 1'b0, {1'b0, a});
      acc(1'b0, 1'b0, 1'b1, 8'h00);
      chk("read valid", 8'h01, {7'h00, CP_RVALID});
      chk(n, e, CP_RDATA);
   endtask
   function automatic logic [7:0] st();
      return {3'h0, CLOCK_DETECT_STATUS};
   endfunction
   function automatic logic [7:0] er();
      return {7'h00, CLOCK_ERROR};
   endfunction
   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task t_reset_values;
      rd(OFS_PAGE_WRAP, 8'h00, "page wrap reset");
      rd(OFS_RATIO_MODE, 8'h00, "ratio mode reset");
      rd(OFS_CHECK_IGNORE, 8'h00, "ignore reset");
      rd(OFS_SOURCE_SELECT, 8'h00, "source reset");
      rd(7'h31, 8'h00, "unmapped");
      chk("missing at reset", 8'h05, st() & 8'h05);
      chk("error at reset", 8'h01, er());
   endtask
   task automatic t_config_fields;
      logic [3:0] ratios [5] = '{RATIO_32, RATIO_64, RATIO_128, RATIO_256, RATIO_512};
      logic [3:0] modes [6] = '{RATE_AUTO, RATE_32K, RATE_44K1, RATE_48K, RATE_88K2, RATE_96K};
      for (int i = 0; i < 6; i++) begin
         wr(OFS_RATIO_MODE, {ratios[i % 5], modes[i]});
         rd(OFS_RATIO_MODE, {ratios[i % 5], modes[i]}, "ratio mode");
         chk("ratio out", {4'h0, ratios[i % 5]}, {4'h0, CONFIGURED_BIT_CLOCK_RATIO});
         chk("mode out", {4'h0, modes[i]}, {4'h0, SAMPLE_RATE_MODE});
      end
      wr(OFS_CHECK_IGNORE, 8'h7c);
      rd(OFS_CHECK_IGNORE, 8'h7c, "ignore");
      wr(OFS_CHECK_IGNORE, 8'h00);
   endtask
   task t_page_wrap;
      wr(BOOK_SELECT_ADDR, 8'h01);
      wr(PAGE_SELECT_ADDR, 8'h01);
      wr(PAGE_LAST_ADDR, 8'h00);
      settle(2);
      chk("pointer next page", 8'h08, {1'b0, CP_POINTER});
      chk("page next", 8'h02, CP_PAGE);
      chk("book", 8'h01, CP_BOOK);
      wr(PAGE_SELECT_ADDR, 8'h00);
      wr(BOOK_SELECT_ADDR, 8'h00);
      // Leaving book 1 at its page end still advances the page once
      wr(PAGE_SELECT_ADDR, 8'h00);
      wr(OFS_PAGE_WRAP, 8'h08);
      wr(BOOK_SELECT_ADDR, 8'h01);
      wr(PAGE_SELECT_ADDR, 8'h01);
      wr(PAGE_LAST_ADDR, 8'h00);
      settle(2);
      chk("pointer same page", 8'h00, {1'b0, CP_POINTER});
      chk("page same", 8'h01, CP_PAGE);
      wr(PAGE_SELECT_ADDR, 8'h00);
      wr(BOOK_SELECT_ADDR, 8'h00);
      rd(OFS_PAGE_WRAP, 8'h08, "page wrap");
   endtask
   task t_clock_checks;
      wr(OFS_RATIO_MODE, 8'h50);
      run = 1'b1;
      settle(1500);
      chk("rate monitor", {4'h0, RATE_32K}, {4'h0, DETECTED_RATE_MONITOR});
      chk("status clean", 8'h00, st());
      chk("error clean", 8'h00, er());
      wr(OFS_RATIO_MODE, {RATIO_64, RATE_48K});
      settle(1000);
      chk("error rate mismatch", 8'h01, er());
      wr(OFS_CHECK_IGNORE, 8'h10);
      settle(20);
      chk("error rate ignored", 8'h00, er());
      chk("status rate", 8'h04, st());
      wr(OFS_RATIO_MODE, {RATIO_64, RATE_32K});
      settle(1000);
      chk("status rate match", 8'h00, st());
      PLL_OVERRATE = 1'b1;
      settle(5);
      chk("status pll", 8'h10, st());
      chk("error pll", 8'h01, er());
      wr(OFS_CHECK_IGNORE, 8'h50);
      settle(5);
      chk("error pll ignored", 8'h00, er());
      PLL_OVERRATE = 1'b0;
      bits = 31;
      settle(1500);
      chk("status ratio", 8'h06, st());
      // Rate fault masked so only the ratio fault can raise the error
      wr(OFS_CHECK_IGNORE, 8'h50);
      settle(5);
      chk("error ratio", 8'h01, er());
      wr(OFS_CHECK_IGNORE, 8'h18);
      settle(5);
      chk("error ratio ignored", 8'h00, er());
      run = 1'b0;
      bits = 39;
      // The host finishes its frame first, then the missing timeout runs
      settle(600);
      chk("status missing", 8'h01, st() & 8'h01);
      wr(OFS_CHECK_IGNORE, 8'h3c);
      settle(5);
      chk("error missing ignored", 8'h00, er());
      wr(OFS_CHECK_IGNORE, 8'h38);
      settle(5);
      chk("error missing", 8'h01, er());
      wr(OFS_CHECK_IGNORE, 8'h00);
   endtask
   task t_source_select;
      DSP_POST_DATA = 1'b1;
      run = 1'b1;
      wr(OFS_SOURCE_SELECT, 8'h00);
      settle(5);
      chk("output processed", 8'h01, {7'h00, SERIAL_AUDIO_OUTPUT});
      wr(OFS_SOURCE_SELECT, 8'h01);
      settle(5);
      chk("output raw", 8'h00, {7'h00, SERIAL_AUDIO_OUTPUT});
      rd(OFS_SOURCE_SELECT, 8'h01, "source");
   endtask
   task final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog sized well above the roughly 5900 cycles of the scenarios
   initial begin
      #2_000_000;
      n_errors++;
      final_report();
   end
   initial begin
      settle(3);
      RESET_N = 1'b1;
      t_reset_values();
      t_config_fields();
      t_page_wrap();
      t_clock_checks();
      t_source_select();
      final_report();
   end
endmodule
